/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import td_proc_pkg::*;
;
  localparam logic [31:0] BASE = 32'h0012_3400;
  logic        i_ref_clk, i_sys_rst, i_wr, i_rd, i_td_load, i_ep_memo;
  logic        i_ep_bulk_in, i_ep_intr, i_sof, i_slow, i_res_valid, i_mem_ready;
  logic        o_token, o_pid_toggle, o_zero_len, o_ep_memo_wr, o_ep_memo, o_irq;
  logic [3:0]  i_addr;
  logic [10:0] i_res_bytes;
  logic [31:0] i_wdata, i_td_addr, o_rdata, head;
  td_s         i_td;
  usb_result_e i_answer, i_res;
  mem_wr_s     o_mem_wr;
  int          n_mismatch, num_checks, cycles, wbase, t;
  logic [1:0]  tg_tab [4] = '{2'h0, 2'h0, 2'h2, 2'h3};
  logic        memo_tab [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic        pid_tab [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  host_td_list_processor i_host_td_list_processor (.*);
  usb_mem_partner i_partner (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_token(o_token),
    .i_pid_toggle(o_pid_toggle), .i_mem_wr(o_mem_wr), .i_ep_memo_wr(o_ep_memo_wr),
    .i_ep_memo(o_ep_memo), .i_answer(i_answer), .i_bytes(11'h10), .i_slow(i_slow),
    .i_stall(4'h2), .o_res(i_res), .o_res_valid(i_res_valid), .o_res_bytes(i_res_bytes),
    .o_mem_ready(i_mem_ready));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  // ============================================================
  // tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata & m, exp);
  endtask

  // bounded poll: 0 token count, 1 write count, 2 interrupt
  task automatic wait_for(input int which, input int n);
    int k;
    k = 0;
    while (k < 400 && !((which == 0 && i_partner.n_tok >= n) ||
           (which == 1 && i_partner.n_wr >= n) || (which == 2 && o_irq === 1'b1)))
    begin
      @(posedge i_ref_clk);
      #1 k++;
    end
    chk(32'(k >= 400), 32'h0);
  endtask

  task automatic load(input logic [1:0] tg, input logic memo, input logic [31:0] pos,
                      input logic [31:0] fin, input logic [31:0] a);
    wbase = i_partner.n_wr;
    t = i_partner.n_tok;
    @(posedge i_ref_clk);
    i_td_load <= 1'b1;
    i_td <= '{toggle: tg, tally: 2'h0, code: 4'h0, buf_pos: pos, buf_end: fin, link: 32'h0};
    i_td_addr <= a;
    i_ep_memo <= memo;
    @(posedge i_ref_clk);
    i_td_load <= 1'b0;
  endtask

  task automatic retire_chk(input logic [31:0] a);
    wait_for(1, wbase + 2);
    chk(i_partner.wa_log[wbase], a);
    chk(i_partner.wa_log[wbase + 1], a + 32'h4);
    chk(i_partner.wd_log[wbase], head);
    head = a;
    rchk(REG_DONE_HEAD, a, 32'hffffffff);
  endtask

  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  // ============================================================
  // sequence
  initial
  begin
    {i_sys_rst, i_ep_intr} = 2'b11;
    {i_wr, i_rd, i_td_load, i_ep_memo, i_ep_bulk_in, i_sof, i_slow} = 7'h0;
    {i_addr, i_wdata, i_td_addr, head, i_td} = '0;
    i_answer = RES_ACK;
    repeat (16) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    rchk(4'hf, 32'h0, 32'hffffffff);
    wr(REG_MASK, 32'h1 << ST_WDH);
    wr(REG_CONTROL, BASE | 32'h4);
    load(2'h2, 1'b0, 32'h1000, 32'h100f, 32'h2000);
    repeat (40) @(posedge i_ref_clk);
    chk(i_partner.n_tok, 32'h0);
    wr(REG_CONTROL, BASE | 32'hc);
    retire_chk(32'h2000);
    chk(i_partner.pid_log[0], 32'h0);
    @(posedge i_ref_clk);
    i_ep_intr <= 1'b0;
    i_ep_bulk_in <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      load(tg_tab[i], memo_tab[i], 32'h1000, 32'h101f, 32'h2100 + 32'(i) * 32'h10);
      retire_chk(32'h2100 + 32'(i) * 32'h10);
      chk(i_partner.pid_log[t], pid_tab[i]);
      chk(i_partner.pid_log[t + 1], !pid_tab[i]);
      chk(i_partner.memo_last, pid_tab[i]);
      chk(i_partner.wd_log[wbase + 1], pid_tab[i]);
    end
    @(posedge i_ref_clk);
    i_answer <= RES_NAK;
    load(2'h2, 1'b0, 32'h1000, 32'h100f, 32'h2200);
    wait_for(0, t + 4);
    i_answer <= RES_ACK;
    retire_chk(32'h2200);
    // errors retire on the third, with the code of the last one
    for (int i = 0; i < 2; i++)
    begin
      @(posedge i_ref_clk);
      i_slow <= 1'b1;
      i_answer <= i == 0 ? RES_PID_ERR : RES_NO_RESP;
      load(2'h2, 1'b0, 32'h1000, 32'h100f, 32'h2300 + 32'(i) * 32'h10);
      wait_for(0, t + 2);
      rchk(REG_TD_STATE, {24'h0, i == 0 ? CC_PID_FAIL : CC_NO_RESP, 4'h6}, 32'hff);
      retire_chk(32'h2300 + 32'(i) * 32'h10);
      chk(i_partner.n_tok, t + 3);
      rchk(REG_TD_STATE, {24'h0, i == 0 ? CC_PID_FAIL : CC_NO_RESP, 4'ha}, 32'hff);
      rchk(REG_STATUS, 32'h6, 32'h6);
      chk(o_irq, 32'h0);
      wr(REG_STATUS, 32'hf);
      rchk(REG_STATUS, 32'h0, 32'h6);
    end
    i_answer <= RES_PID_ERR;
    load(2'h2, 1'b0, 32'h1000, 32'h100f, 32'h2400);
    wait_for(0, t + 2);
    i_answer <= RES_ACK;
    retire_chk(32'h2400);
    rchk(REG_TD_STATE, 32'h0, 32'hfc);
    // slow answers leave time to look at the descriptor between packets
    load(2'h2, 1'b0, 32'h1000, 32'h101f, 32'h2500);
    wait_for(0, t + 2);
    chk(o_zero_len, 32'h0);
    rchk(REG_TD_BUF, 32'h1010, 32'hffffffff);
    rchk(REG_TD_STATE, 32'h3, 32'h3);
    retire_chk(32'h2500);
    rchk(REG_TD_BUF, 32'h0, 32'hffffffff);
    load(2'h2, 1'b0, 32'h0, 32'h1f, 32'h2600);
    retire_chk(32'h2600);
    chk(i_partner.n_tok, t + 1);
    chk(o_zero_len, 32'h1);
    rchk(REG_TD_STATE, 32'h3, 32'h3);
    // frame start writes frame number and a new done head, then flags; an unchanged head is skipped
    t = i_partner.n_wr;
    wr(REG_STATUS, 32'hf);
    #1 chk(o_irq, 32'h0);
    @(posedge i_ref_clk);
    i_sof <= 1'b1;
    @(posedge i_ref_clk);
    i_sof <= 1'b0;
    wait_for(2, 0);
    chk(i_partner.n_wr, t + 2);
    chk(i_partner.wa_log[t], BASE);
    chk(i_partner.wa_log[t + 1], BASE + 32'h4);
    chk(i_partner.wd_log[t + 1], head);
    rchk(REG_STATUS, 32'h1, 32'h1);
    wr(REG_STATUS, 32'h1);
    repeat (2) @(posedge i_ref_clk);
    #1 chk(o_irq, 32'h0);
    @(posedge i_ref_clk);
    i_sof <= 1'b1;
    @(posedge i_ref_clk);
    i_sof <= 1'b0;
    repeat (60) @(posedge i_ref_clk);
    chk(i_partner.n_wr, t + 3);
    #1 chk(o_irq, 32'h0);
    summarize();
  end
endmodule // tb_top
`default_nettype wire

/* File: tb/usb_mem_partner.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// far side: usb function answering tokens, system memory
module usb_mem_partner
  import td_proc_pkg::*;
(
  input  wire logic        i_ref_clk,    // clock
  input  wire logic        i_sys_rst,    // async reset, high
  input  wire logic        i_token,      // in token request
  input  wire logic        i_pid_toggle, // data pid of token
  input  wire mem_wr_s     i_mem_wr,     // memory write
  input  wire logic        i_ep_memo_wr, // memo update pulse
  input  wire logic        i_ep_memo,    // memo value
  input  wire usb_result_e i_answer,     // answer to give
  input  wire logic [10:0] i_bytes,      // bytes to report
  input  wire logic        i_slow,       // answer late
  input  wire logic [3:0]  i_stall,      // memory wait cycles
  output var usb_result_e  o_res,        // transaction result
  output logic             o_res_valid,  // result strobe
  output logic      [10:0] o_res_bytes,  // bytes moved
  output logic             o_mem_ready   // memory write accepted
);
  int          n_tok = 0;
  int          n_wr = 0;
  logic        memo_last;
  logic        pid_log [$];
  logic [31:0] wa_log [$];
  logic [31:0] wd_log [$];
  logic        busy;
  logic [3:0]  ans_cnt;
  logic [3:0]  mem_cnt;

  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      busy        <= 1'b0;
      ans_cnt     <= 4'h0;
      mem_cnt     <= 4'h0;
      o_res_valid <= 1'b0;
      o_res       <= RES_ACK;
      o_res_bytes <= 11'h0;
      o_mem_ready <= 1'b0;
    end
    else
    begin
      // released result lines keep moving so a stale value never matches
      o_res_valid <= 1'b0;
      o_res       <= usb_result_e'(~o_res);
      o_res_bytes <= ~o_res_bytes;
      if (i_token)
      begin
        n_tok++;
        pid_log.push_back(i_pid_toggle);
        busy    <= 1'b1;
        ans_cnt <= i_slow ? 4'hc : 4'h2;
      end
      else if (busy && ans_cnt == 4'h0)
      begin
        busy        <= 1'b0;
        o_res_valid <= 1'b1;
        o_res       <= i_answer;
        o_res_bytes <= i_bytes;
      end
      else if (busy)
        ans_cnt <= ans_cnt - 4'h1;
      if (i_mem_wr.valid && o_mem_ready)
      begin
        wa_log.push_back(i_mem_wr.addr);
        wd_log.push_back(i_mem_wr.data);
        n_wr++;
        o_mem_ready <= 1'b0;
        mem_cnt     <= i_stall;
      end
      else if (i_mem_wr.valid && mem_cnt == 4'h0)
        o_mem_ready <= 1'b1;
      else if (i_mem_wr.valid)
        mem_cnt <= mem_cnt - 4'h1;
      if (i_ep_memo_wr)
        memo_last <= i_ep_memo;
    end
  end
endmodule // usb_mem_partner
`default_nettype wire

/* File: verilog/done_link_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module done_link_mem #(
  parameter int DEPTH = 16
) (
  input  wire logic                     i_ref_clk, // clock
  input  wire logic                     i_we,      // write enable
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,   // write slot
  input  wire logic [31:0]              i_wdata,   // descriptor address
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,   // read slot
  output logic      [31:0]              o_rdata    // registered read data
);
  logic [31:0] mem [DEPTH];
  always_ff @(posedge i_ref_clk)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
    o_rdata <= mem[i_raddr];
  end
endmodule // done_link_mem
`default_nettype wire

/* File: verilog/host_td_list_processor.sv */
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module host_td_list_processor
  import td_proc_pkg::*;
(
  input  wire logic              i_ref_clk,      // 125 mhz clock
  input  wire logic              i_sys_rst,      // async reset, high
  input  wire logic [3:0]        i_addr,         // register index
  input  wire logic [31:0]       i_wdata,        // write data
  input  wire logic              i_wr,           // write strobe
  input  wire logic              i_rd,           // read strobe
  output logic      [31:0]       o_rdata,        // read data, next cycle
  input  wire logic              i_td_load,      // load a descriptor
  input  wire td_s               i_td,           // descriptor words
  input  wire logic [31:0]       i_td_addr,      // descriptor address
  input  wire logic              i_ep_memo,      // endpoint toggle memo
  input  wire logic              i_ep_bulk_in,   // endpoint is bulk in
  input  wire logic              i_ep_intr,      // endpoint is interrupt
  input  wire logic              i_sof,          // start-of-frame pulse
  input  wire logic              i_res_valid,    // transaction result strobe
  input  wire usb_result_e       i_res,          // transaction result
  input  wire logic [10:0]       i_res_bytes,    // bytes moved
  input  wire logic              i_mem_ready,    // memory write accepted
  output logic                   o_token,        // in token request pulse
  output logic                   o_pid_toggle,   // data pid for token
  output logic                   o_zero_len,     // buffer position is zero
  output mem_wr_s                o_mem_wr,       // memory write
  output logic                   o_ep_memo_wr,   // memo update pulse
  output logic                   o_ep_memo,      // memo value to write
  output logic                   o_irq           // level interrupt
);

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    S_IDLE,
    S_TOKEN,
    S_WAIT,
    S_WB_TD,
    S_WB_ED,
    S_WB_FRAME,
    S_WB_HEAD,
    S_FLAG
  } tdp_state_e;

  typedef struct packed {
    tdp_state_e  st;
    logic        have_td;
    td_s         td;
    logic [31:0] td_addr;
    logic [31:0] control;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [31:0] done_head;
    logic [31:0] frame_head;
    logic [15:0] frame_no;
    logic        sof_pend;
    logic [31:0] prev_head;
    logic [31:0] rdata;
    logic        token;
    logic        pid;
    logic        zero_len;
    mem_wr_s     mem_wr;
    logic        memo_wr;
    logic        memo;
    logic        irq;
    logic [3:0]  slot;
  } tdp_s;

  tdp_s q_reg;
  tdp_s q_next;

  logic       pid_tgl;
  logic [1:0] next_field;
  logic [31:0] link_rdata;

  toggle_pick u_tgl (
    .i_toggle_field (q_reg.td.toggle),
    .i_ep_memo      (i_ep_memo),
    .o_pid_toggle   (pid_tgl),
    .o_next_field   (next_field)
  );

  done_link_mem #(.DEPTH(16)) u_mem (
    .i_ref_clk (i_ref_clk),
    .i_we      (q_reg.st == S_WB_TD && q_reg.mem_wr.valid && i_mem_ready),
    .i_waddr   (q_reg.slot),
    .i_wdata   (q_reg.td_addr),
    .i_raddr   (i_addr),
    .o_rdata   (link_rdata)
  );

  function automatic logic sched_ok(input logic [31:0] ctl);
    sched_ok = ctl[CTL_PERIODIC] & ctl[CTL_ISO];
  endfunction

  function automatic mem_wr_s mk_wr(input logic [31:0] a, input logic [31:0] d);
    mk_wr.valid = 1'b1;
    mk_wr.addr  = a;
    mk_wr.data  = d;
  endfunction

  // ==========================================================
  // next state
  always_comb
  begin
    q_next          = q_reg;
    q_next.token    = 1'b0;
    // registered so the pid travels in the same cycle as the token pulse
    q_next.pid      = pid_tgl;
    q_next.memo_wr  = 1'b0;
    q_next.rdata    = 32'h0;
    q_next.zero_len = (q_reg.td.buf_pos == 32'h0);
    if (i_sof)
      q_next.sof_pend = 1'b1;
    if (q_reg.mem_wr.valid && i_mem_ready)
      q_next.mem_wr.valid = 1'b0;

    // register bus
    if (i_wr)
    begin
      case (i_addr)
        REG_CONTROL: q_next.control = i_wdata;
        REG_STATUS:  q_next.status = q_reg.status & ~i_wdata[ST_W-1:0];
        REG_MASK:    q_next.mask = i_wdata[ST_W-1:0];
        default:     q_next.control = q_reg.control;
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        REG_CONTROL:   q_next.rdata = q_reg.control;
        REG_STATUS:    q_next.rdata = {29'h0, q_reg.status};
        REG_MASK:      q_next.rdata = {29'h0, q_reg.mask};
        REG_DONE_HEAD: q_next.rdata = q_reg.done_head;
        REG_FRAME:     q_next.rdata = {16'h0, q_reg.frame_no};
        REG_TD_STATE:  q_next.rdata = {24'h0, q_reg.td.code, q_reg.td.tally, q_reg.td.toggle};
        REG_TD_PTR:    q_next.rdata = q_reg.td.link;
        REG_TD_BUF:    q_next.rdata = q_reg.td.buf_pos;
        default:       q_next.rdata = 32'h0;
      endcase
    end

    case (q_reg.st)
      S_IDLE:
      begin
        if (q_reg.sof_pend)
        begin
          // frame writeback once idle, ahead of a loaded descriptor
          q_next.sof_pend = 1'b0;
          q_next.frame_no = q_reg.frame_no + 16'h1;
          q_next.mem_wr   = mk_wr(q_reg.control & 32'hffff_ff00, {16'h0, q_reg.frame_no});
          q_next.st       = S_WB_FRAME;
        end
        else if (i_td_load && !q_reg.have_td)
        begin
          q_next.td      = i_td;
          q_next.td_addr = i_td_addr;
          q_next.have_td = 1'b1;
        end
        // interrupt endpoints need both schedule bits
        else if (q_reg.have_td && (!i_ep_intr || sched_ok(q_reg.control)))
          q_next.st = S_TOKEN;
      end
      S_TOKEN:
      begin
        // bulk in keeps tokening through naks
        q_next.token = 1'b1;
        q_next.st    = S_WAIT;
      end
      S_WAIT:
      begin
        if (i_res_valid)
        begin
          case (i_res)
            RES_ACK:
            begin
              q_next.td.toggle = next_field;
              q_next.td.tally = 2'h0;
              q_next.td.code = CC_NO_ERROR;
              q_next.td.buf_pos = q_reg.td.buf_pos + {21'h0, i_res_bytes};
              if (q_reg.td.buf_pos == 32'h0 || q_next.td.buf_pos > q_reg.td.buf_end)
              begin
                q_next.td.buf_pos = 32'h0;
                q_next.mem_wr = mk_wr(q_reg.td_addr, q_reg.done_head);
                q_next.st     = S_WB_TD;
              end
              else
                q_next.st = S_TOKEN;
            end
            RES_NAK:
            begin
              q_next.st = i_ep_bulk_in ? S_TOKEN : S_IDLE;
            end
            default:
            begin
              q_next.td.code = (i_res == RES_PID_ERR) ? CC_PID_FAIL : CC_NO_RESP;
              if (q_reg.td.tally == TALLY_LIMIT)
              begin
                q_next.status[ST_ERROR] = 1'b1;
                q_next.mem_wr = mk_wr(q_reg.td_addr, q_reg.done_head);
                q_next.st     = S_WB_TD;
              end
              else
              begin
                q_next.td.tally = q_reg.td.tally + 2'h1;
                q_next.st       = S_TOKEN;
              end
            end
          endcase
        end
      end
      S_WB_TD:
      begin
        if (!q_reg.mem_wr.valid || i_mem_ready)
        begin
          // endpoint write follows at once
          // carried toggle is the next data pid, also after an error retire
          q_next.mem_wr   = mk_wr(q_reg.td_addr + 32'h4, {31'h0, pid_tgl});
          q_next.memo_wr  = 1'b1;
          q_next.memo     = pid_tgl;
          q_next.done_head = q_reg.td_addr;
          q_next.slot     = q_reg.slot + 4'h1;
          q_next.st       = S_WB_ED;
        end
      end
      S_WB_ED:
      begin
        if (!q_reg.mem_wr.valid || i_mem_ready)
        begin
          q_next.have_td = 1'b0;
          q_next.status[ST_RETIRE] = 1'b1;
          q_next.st = S_IDLE;
        end
      end
      S_WB_FRAME:
      begin
        if (!q_reg.mem_wr.valid || i_mem_ready)
        begin
          // skip a head already handed over
          if (q_reg.done_head == q_reg.prev_head)
            q_next.st = S_IDLE;
          else
          begin
            q_next.mem_wr = mk_wr((q_reg.control & 32'hffff_ff00) + 32'h4, q_reg.done_head);
            q_next.st     = S_WB_HEAD;
          end
        end
      end
      S_WB_HEAD:
      begin
        // flag only after head write accepted
        if (!q_reg.mem_wr.valid || i_mem_ready)
        begin
          q_next.prev_head = q_reg.done_head;
          q_next.st = S_FLAG;
        end
      end
      S_FLAG:
      begin
        q_next.status[ST_WDH] = 1'b1;
        q_next.st = S_IDLE;
      end
      default: q_next.st = S_IDLE;
    endcase

    q_next.irq = |(q_next.status & q_next.mask);
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      q_reg <= '0;
    else
      q_reg <= q_next;
  end

  always_comb
  begin
    o_rdata      = q_reg.rdata;
    o_token      = q_reg.token;
    o_pid_toggle = q_reg.pid;
    o_zero_len   = q_reg.zero_len;
    o_mem_wr     = q_reg.mem_wr;
    o_ep_memo_wr = q_reg.memo_wr;
    o_ep_memo    = q_reg.memo;
    o_irq        = q_reg.irq;
  end

  // ==========================================================
  // checks
  // error at limit retires
  retire_at_limit_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (q_reg.st == S_WAIT && i_res_valid && i_res inside {RES_PID_ERR, RES_NO_RESP}
     && q_reg.td.tally == TALLY_LIMIT) |=> q_reg.st == S_WB_TD)
    else $error("descriptor not retired at tally limit");
  tally_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (q_reg.st == S_WAIT && i_res_valid && i_res == RES_ACK) |=> q_reg.td.tally == 2'h0)
    else $error("tally not cleared");
  pid_code_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (q_reg.st == S_WAIT && i_res_valid && i_res == RES_PID_ERR) |=> q_reg.td.code == CC_PID_FAIL)
    else $error("wrong pid failure code");
  nak_retoken_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (q_reg.st == S_WAIT && i_res_valid && i_res == RES_NAK && i_ep_bulk_in) |=> ##1 o_token)
    else $error("no token after bulk nak");
  td_then_ed_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (q_reg.st == S_WB_TD && $past(q_reg.st) != S_WB_TD) |-> ##[1:64] q_reg.st == S_WB_ED)
    else $error("endpoint write did not follow");
  flag_after_head_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $rose(q_reg.status[ST_WDH]) |-> $past(q_reg.st, 1) == S_FLAG && !o_mem_wr.valid)
    else $error("writeback flag before head write");
  intr_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (q_reg.st == S_IDLE && !q_reg.sof_pend && q_reg.have_td && i_ep_intr
     && !sched_ok(q_reg.control)) |=> q_reg.st != S_TOKEN)
    else $error("interrupt scheduled while disabled");
  toggle_adv_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (q_reg.st == S_WAIT && i_res_valid && i_res == RES_ACK) |=> q_reg.td.toggle[1]
      && q_reg.td.toggle[0] != $past(pid_tgl))
    else $error("toggle not advanced");

endmodule // host_td_list_processor
`default_nettype wire

/* File: verilog/td_proc_pkg.sv */
// ============================================================
// Operation
// - each transfer descriptor carries a two-bit toggle field that forms or checks the data pid.
// - toggle upper bit 0 takes the endpoint toggle memo, upper bit 1 takes the field's lower bit.
// - every successful data packet advances the toggle field of the active descriptor.
// - each transmission error bumps the tally; an error while the tally is 2 retires the descriptor.
// - an error-free transaction clears the retry error tally to 0.
// - the completion code field holds the status of the last attempted transaction.
// - the buffer position holds the next byte address and advances as bytes move.
// - a buffer position of zero means a zero-length packet or a fully moved buffer.
// - interrupt transactions run only while periodic and isochronous schedule bits are both 1.
// - a pid check failure is code 06h and a silent device is code 05h.
// - an active bulk in endpoint keeps issuing in tokens while the device answers nak.
// - each finished transfer writes the descriptor and then the endpoint, back to back.
// - frame number and done head go to memory at the next frame start once transfers finish; the code writes once idle, even with a descriptor loaded.
package td_proc_pkg;

  localparam int          ADDR_W        = 32;
  localparam logic [1:0]  TGL_FROM_TD   = 2'h2;
  localparam logic [3:0]  CC_NO_ERROR   = 4'h0;
  localparam logic [3:0]  CC_NO_RESP    = 4'h5;
  localparam logic [3:0]  CC_PID_FAIL   = 4'h6;
  localparam logic [3:0]  CC_NOT_ACCESS = 4'hf;
  localparam logic [1:0]  TALLY_LIMIT   = 2'h2;
  localparam int          CTL_PERIODIC  = 2;
  localparam int          CTL_ISO       = 3;

  // register offsets
  localparam logic [3:0]  REG_CONTROL   = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h1;
  localparam logic [3:0]  REG_MASK      = 4'h2;
  localparam logic [3:0]  REG_DONE_HEAD = 4'h3;
  localparam logic [3:0]  REG_FRAME     = 4'h4;
  localparam logic [3:0]  REG_TD_STATE  = 4'h5;
  localparam logic [3:0]  REG_TD_PTR    = 4'h6;
  localparam logic [3:0]  REG_TD_BUF    = 4'h7;

  // status bits
  localparam int          ST_WDH        = 0;
  localparam int          ST_RETIRE     = 1;
  localparam int          ST_ERROR      = 2;
  localparam int          ST_W          = 3;

  typedef enum logic [1:0] {
    RES_ACK,
    RES_NAK,
    RES_PID_ERR,
    RES_NO_RESP
  } usb_result_e;

  typedef struct packed {
    logic [1:0]  toggle;
    logic [1:0]  tally;
    logic [3:0]  code;
    logic [31:0] buf_pos;
    logic [31:0] buf_end;
    logic [31:0] link;
  } td_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } mem_wr_s;

endpackage : td_proc_pkg

/* File: verilog/toggle_pick.sv */
`timescale 1ns/100ps
`default_nettype none
module toggle_pick
  import td_proc_pkg::*;
(
  input  wire logic [1:0] i_toggle_field, // descriptor toggle field
  input  wire logic       i_ep_memo,      // endpoint toggle memo
  output logic            o_pid_toggle,   // data pid in use
  output logic [1:0]      o_next_field    // field after a good packet
);
  always_comb
  begin
    o_pid_toggle = i_toggle_field[1] ? i_toggle_field[0] : i_ep_memo;
    o_next_field = {1'b1, ~o_pid_toggle};
  end
endmodule // toggle_pick
`default_nettype wire
